/* File: pkg/sdp_pkg.sv */
// Constants, command codes and the strobe decode function of the synchronous memory pin port.
// Assumes a single 125 MHz core clock from which the system bus clock is divided.
package sdp_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS     = 8;
  localparam int SYS_BUS_PERIOD_NS = 16;
  // Core cycles per half period of the system bus clock, never below one.
  localparam int BUS_HALF_CYCLES   = (SYS_BUS_PERIOD_NS / (2 * CLK_PERIOD_NS)) < 1 ? 1 :
                                     (SYS_BUS_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam int CAS_LATENCY       = 2;

  // ==========================================================================
  // Widths and pin layout
  localparam int DATA_W        = 32;
  localparam int LANES         = 4;
  localparam int MEM_ADDR_W    = 15;
  localparam int PIN_ADDR_W    = 20;
  localparam int ADDR_HI_MSB   = 19;
  localparam int ADDR_HI_LSB   = 16;
  localparam int ADDR_LO_MSB   = 14;
  localparam int ADDR_LO_LSB   = 5;
  localparam int MEM_A10_POS   = 10;

  // ==========================================================================
  // Reset levels
  localparam logic [1:0] RST_CLK_OUT  = 2'h3;
  localparam logic [3:0] RST_CS_N     = 4'h0_00F;
  localparam logic [3:0] RST_DQM      = 4'h0_00F;
  localparam logic       RST_STROBE   = 1'b1;
  localparam logic       RST_CKE      = 1'b1;
  localparam logic       RST_FLASH_N  = 1'b0;

  typedef enum logic [2:0] {
    CMD_NOP        = 3'b000,
    CMD_ACTIVE     = 3'b001,
    CMD_READ       = 3'b010,
    CMD_WRITE      = 3'b011,
    CMD_BURST_STOP = 3'b100,
    CMD_PRECHARGE  = 3'b101,
    CMD_REFRESH    = 3'b110,
    CMD_MODE_SET   = 3'b111
  } sdp_cmd_t;

  // Returns {row strobe, column strobe, write strobe} levels, all active low.
  function automatic logic [2:0] sdp_strobes(input sdp_cmd_t cmd);
    case (cmd)
      CMD_ACTIVE:     sdp_strobes = 3'b011;
      CMD_READ:       sdp_strobes = 3'b101;
      CMD_WRITE:      sdp_strobes = 3'b100;
      CMD_BURST_STOP: sdp_strobes = 3'b110;
      CMD_PRECHARGE:  sdp_strobes = 3'b010;
      CMD_REFRESH:    sdp_strobes = 3'b001;
      CMD_MODE_SET:   sdp_strobes = 3'b000;
      default:        sdp_strobes = 3'b111;
    endcase
  endfunction

endpackage

/* File: pkg/sdp_cap_if.sv */
// Link between the pin port and its feedback clock capture unit.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns
interface sdp_cap_if;
  import sdp_pkg::*;
  logic              arm;
  logic              busy;
  logic              valid;
  logic [DATA_W-1:0] data;
  modport ctl (output arm, input busy, input valid, input data);
  modport cap (input arm, output busy, output valid, output data);
endinterface

/* File: verilog/sdp_fb_capture.sv */
// Read data capture timed by the feedback clock returned from the memory clock net.
// Assumes the feedback clock and data pins are asynchronous to CLK and slow enough to sample.
`timescale 1ns/1ns
module sdp_fb_capture
  import sdp_pkg::*;
#(
  parameter int CAS_LAT = CAS_LATENCY
) (
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire logic              fb_clk,
  input  wire logic [DATA_W-1:0] dq_in,
  sdp_cap_if.cap                 cap
);

  typedef struct packed {
    logic              fb_s1;
    logic              fb_s2;
    logic              fb_s3;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [3:0]        cnt;
    logic              busy;
    logic              valid;
    logic [DATA_W-1:0] data;
  } sdp_cap_t;

  sdp_cap_t st_q;
  sdp_cap_t st_d;
  logic     fb_rise;

  // ==========================================================================
  // Capture
  // Data is delayed through the same two stages as the feedback clock so
  // that both are seen with equal latency when the edge is found.
  assign fb_rise = st_q.fb_s2 & ~st_q.fb_s3;

  always_comb begin
    st_d       = st_q;
    st_d.fb_s1 = fb_clk;
    st_d.fb_s2 = st_q.fb_s1;
    st_d.fb_s3 = st_q.fb_s2;
    st_d.dq_s1 = dq_in;
    st_d.dq_s2 = st_q.dq_s1;
    st_d.valid = 1'b0;
    if (cap.arm) begin
      // The first rise after arming is the edge that takes the read command.
      st_d.cnt  = 4'(CAS_LAT + 1);
      st_d.busy = 1'b1;
    end else if (st_q.busy && fb_rise) begin
      st_d.cnt = st_q.cnt - 4'h0_001;
      if (st_q.cnt == 4'h0_001) begin
        st_d.busy  = 1'b0;
        st_d.valid = 1'b1;
        st_d.data  = st_q.dq_s2;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign cap.busy  = st_q.busy;
  assign cap.valid = st_q.valid;
  assign cap.data  = st_q.data;

  // ==========================================================================
  // Checks
  property p_fb_capture;
    @(posedge CLK) disable iff (!RSTN)
    st_q.busy && !cap.arm && fb_rise && st_q.cnt == 4'h0_001 |=>
      cap.valid && cap.data == $past(st_q.dq_s2) && !cap.busy;
  endproperty
  a_fb_capture: assert property (p_fb_capture) else $error("read data not taken on feedback edge");

  property p_no_early;
    @(posedge CLK) disable iff (!RSTN)
    cap.arm |=> !cap.valid [*4];
  endproperty
  a_no_early: assert property (p_no_early) else $error("read data taken too early");

endmodule

/* File: verilog/sdp_pin_interface.sv */
// Pin-level synchronous memory port: memory clocks, command strobes, masks, flash reset.
// Assumes requests come from controller logic on CLK; the feedback clock and read data are
// asynchronous pins.
`timescale 1ns/1ns
module sdp_pin_interface
  import sdp_pkg::*;
#(
  parameter int CAS_LAT = CAS_LATENCY
) (
  input  wire logic                  CLK,
  input  wire logic                  RSTN,
  input  wire logic [1:0]            MEM_CLOCK_PIN_ENABLE,
  input  wire logic                  CLOCK_SUSPEND,
  input  wire logic                  FLASH_RELEASE,
  input  wire logic                  REQ_VALID,
  output var  logic                  REQ_READY,
  input  wire sdp_cmd_t              REQ_CMD,
  input  wire logic [1:0]            REQ_CHIP,
  input  wire logic [MEM_ADDR_W-1:0] REQ_ADDR,
  input  wire logic [LANES-1:0]      REQ_BYTE_MASK,
  input  wire logic [DATA_W-1:0]     WR_DATA,
  output var  logic                  RD_VALID,
  output var  logic [DATA_W-1:0]     RD_DATA,
  output var  logic [1:0]            MEM_CLOCK_OUT,
  input  wire logic                  MEM_FEEDBACK_CLOCK_IN,
  output var  logic                  MEM_CKE,
  output var  logic [3:0]            MEM_CHIP_SELECT_N,
  output var  logic                  MEM_ROW_STROBE_N,
  output var  logic                  MEM_COL_STROBE_N,
  output var  logic                  MEM_WRITE_STROBE_N,
  output var  logic [LANES-1:0]      MEM_DQM,
  output var  logic [PIN_ADDR_W-1:0] MEM_ADDR,
  output var  logic                  MEM_ADDR_BIT10,
  input  wire logic [DATA_W-1:0]     MEM_DQ_IN,
  output var  logic [DATA_W-1:0]     MEM_DQ_OUT,
  output var  logic                  MEM_DQ_OE_N,
  output var  logic                  FLASH_RESET_POWERDOWN_N
);

  typedef struct packed {
    logic [3:0]            div;
    logic                  bus_clk;
    logic [1:0]            clk_out;
    logic                  cke;
    logic [3:0]            cs_n;
    logic [2:0]            strobes;
    logic [LANES-1:0]      dqm;
    logic [PIN_ADDR_W-1:0] addr;
    logic                  a10;
    logic [DATA_W-1:0]     dq_out;
    logic                  dq_oe_n;
    logic                  flash_n;
    logic                  ready;
    logic                  arm;
  } sdp_state_t;

  localparam logic [3:0] DIV_LAST = 4'(BUS_HALF_CYCLES - 1);

  sdp_state_t st_q;
  sdp_state_t st_d;
  sdp_cap_if  cap_if ();
  logic       tick;
  logic       fall;
  logic       fire;

  sdp_fb_capture #(
    .CAS_LAT (CAS_LAT)
  ) u_capture (
    .CLK    (CLK),
    .RSTN   (RSTN),
    .fb_clk (MEM_FEEDBACK_CLOCK_IN),
    .dq_in  (MEM_DQ_IN),
    .cap    (cap_if.ctl)
  );

  // ==========================================================================
  // Clock generation and command issue
  // Commands change on the falling memory clock edge so that they are stable
  // a full half period around the rising edge on which the memory samples.
  assign tick = (st_q.div == DIV_LAST);
  assign fall = tick && st_q.bus_clk;
  assign fire = fall && st_q.ready && REQ_VALID;

  always_comb begin
    st_d         = st_q;
    st_d.div     = tick ? 4'h0_000 : st_q.div + 4'h0_001;
    st_d.bus_clk = tick ? ~st_q.bus_clk : st_q.bus_clk;
    // The output clocks are copies of the bus clock flop, so they share its rate.
    st_d.clk_out = MEM_CLOCK_PIN_ENABLE & {2{st_d.bus_clk}};
    st_d.cke     = ~CLOCK_SUSPEND;
    st_d.flash_n = FLASH_RELEASE;
    st_d.arm     = 1'b0;
    if (fall) begin
      st_d.cs_n    = 4'h0_00F;
      st_d.strobes = 3'b111;
      st_d.dq_oe_n = 1'b1;
      // Read masks stay put until the read data have come back.
      if (!(st_q.arm || cap_if.busy)) begin
        st_d.dqm = 4'h0_00F;
      end
      if (fire) begin
        st_d.cs_n           = ~(4'h0_001 << REQ_CHIP);
        st_d.strobes        = sdp_strobes(REQ_CMD);
        st_d.addr           = '0;
        st_d.addr[ADDR_HI_MSB:ADDR_HI_LSB] = REQ_ADDR[MEM_ADDR_W-1:MEM_A10_POS+1];
        st_d.addr[ADDR_LO_MSB:ADDR_LO_LSB] = REQ_ADDR[MEM_A10_POS-1:0];
        st_d.a10            = REQ_ADDR[MEM_A10_POS];
        if (REQ_CMD == CMD_WRITE) begin
          st_d.dqm     = REQ_BYTE_MASK;
          st_d.dq_out  = WR_DATA;
          st_d.dq_oe_n = 1'b0;
        end else if (REQ_CMD == CMD_READ) begin
          st_d.dqm = REQ_BYTE_MASK;
          st_d.arm = 1'b1;
        end
      end
    end
    // A read in flight blocks new commands; the feedback clock must be running.
    st_d.ready = (st_d.div == DIV_LAST) && st_d.bus_clk && !fire && !st_q.arm &&
                 !cap_if.busy;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_q         <= '0;
      st_q.bus_clk <= 1'b1;
      st_q.clk_out <= RST_CLK_OUT;
      st_q.cke     <= RST_CKE;
      st_q.cs_n    <= RST_CS_N;
      st_q.strobes <= {3{RST_STROBE}};
      st_q.dqm     <= RST_DQM;
      st_q.dq_oe_n <= 1'b1;
      st_q.flash_n <= RST_FLASH_N;
    end else begin
      st_q <= st_d;
    end
  end

  assign cap_if.arm              = st_q.arm;
  assign REQ_READY               = st_q.ready;
  assign RD_VALID                = cap_if.valid;
  assign RD_DATA                 = cap_if.data;
  assign MEM_CLOCK_OUT           = st_q.clk_out;
  assign MEM_CKE                 = st_q.cke;
  assign MEM_CHIP_SELECT_N       = st_q.cs_n;
  assign MEM_ROW_STROBE_N        = st_q.strobes[2];
  assign MEM_COL_STROBE_N        = st_q.strobes[1];
  assign MEM_WRITE_STROBE_N      = st_q.strobes[0];
  assign MEM_DQM                 = st_q.dqm;
  assign MEM_ADDR                = st_q.addr;
  assign MEM_ADDR_BIT10          = st_q.a10;
  assign MEM_DQ_OUT              = st_q.dq_out;
  assign MEM_DQ_OE_N             = st_q.dq_oe_n;
  assign FLASH_RESET_POWERDOWN_N = st_q.flash_n;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  property p_reset_high;
    disable iff (1'b0) !RSTN |=> MEM_CLOCK_OUT == 2'h3 && MEM_CKE && MEM_CHIP_SELECT_N == 4'h0_00F
      && MEM_ROW_STROBE_N && MEM_COL_STROBE_N && MEM_WRITE_STROBE_N && MEM_DQM == 4'h0_00F;
  endproperty
  a_reset_high: assert property (p_reset_high) else $error("pins not high after reset");

  property p_flash_low;
    disable iff (1'b0) !RSTN ##1 !FLASH_RELEASE |=> !FLASH_RESET_POWERDOWN_N;
  endproperty
  a_flash_low: assert property (p_flash_low) else $error("flash line left low-release");

  property p_clk_off;
    !MEM_CLOCK_PIN_ENABLE[1] [*2] |-> !MEM_CLOCK_OUT[1];
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("disabled clock pin not low");

  property p_clk_rate;
    MEM_CLOCK_PIN_ENABLE[0] [*3] ##0 $rose(MEM_CLOCK_OUT[0]) ##1 MEM_CLOCK_PIN_ENABLE[0] |->
      $fell(MEM_CLOCK_OUT[0]) && MEM_CLOCK_OUT[0] == st_q.bus_clk;
  endproperty
  a_clk_rate: assert property (p_clk_rate) else $error("memory clock not at bus rate");

  property p_write;
    fire && REQ_CMD == CMD_WRITE |=> MEM_ROW_STROBE_N && !MEM_COL_STROBE_N &&
      !MEM_WRITE_STROBE_N && !MEM_DQ_OE_N && MEM_DQM == $past(REQ_BYTE_MASK)
      ##1 !MEM_DQ_OE_N ##1 (MEM_DQ_OE_N || $past(fire && REQ_CMD == CMD_WRITE));
  endproperty
  a_write: assert property (p_write) else $error("write command or mask wrong");

  property p_lanes;
    fire && REQ_CMD == CMD_WRITE |=> MEM_DQ_OUT[31:24] == $past(WR_DATA[31:24]) &&
      MEM_DQ_OUT[7:0] == $past(WR_DATA[7:0]) && MEM_DQM[3] == $past(REQ_BYTE_MASK[3]);
  endproperty
  a_lanes: assert property (p_lanes) else $error("byte lane mapping wrong");

  property p_read;
    fire && REQ_CMD == CMD_READ |=> MEM_ROW_STROBE_N && !MEM_COL_STROBE_N && MEM_WRITE_STROBE_N
      && MEM_DQ_OE_N && MEM_DQM == $past(REQ_BYTE_MASK) ##1 !REQ_READY [*2];
  endproperty
  a_read: assert property (p_read) else $error("read command or mask wrong");

  property p_addr;
    fire |=> MEM_ADDR[19:16] == $past(REQ_ADDR[14:11]) && MEM_ADDR[14:5] == $past(REQ_ADDR[9:0])
      && MEM_ADDR_BIT10 == $past(REQ_ADDR[10]) && $countones(~MEM_CHIP_SELECT_N) == 1;
  endproperty
  a_addr: assert property (p_addr) else $error("address or select mapping wrong");

  property p_deselect;
    fall && !fire |=> MEM_CHIP_SELECT_N == 4'h0_00F;
  endproperty
  a_deselect: assert property (p_deselect) else $error("select asserted without request");

  c_write: cover property (fire && REQ_CMD == CMD_WRITE);
  c_read_back: cover property (RD_VALID);
  c_clk_off: cover property (!MEM_CLOCK_PIN_ENABLE[0] ##1 !MEM_CLOCK_PIN_ENABLE[0]);
  c_flash_up: cover property ($rose(FLASH_RESET_POWERDOWN_N));

endmodule

/* File: tb/sdp_mem_model.sv */
// Behavioural synchronous memory standing on the far side of the pin port.
// Assumes command pins are sampled on rising edges of memory clock pin 0.
`timescale 1ns/1ns
module sdp_mem_model
  import sdp_pkg::*;
#(
  parameter int FB_HALF_NS = 32
) (
  input  wire logic        clk_pin,
  input  wire logic [3:0]  cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [3:0]  dqm,
  input  wire logic [19:0] addr,
  input  wire logic        addr_bit10,
  input  wire logic [31:0] dq_out,
  input  wire logic        dq_oe_n,
  input  wire logic        slow,
  output var  logic        fb_clk,
  output var  logic [31:0] dq_in
);
  // ==========================================================================
  // Storage and command decode
  logic [31:0]      mem [int];
  logic [31:0]      wword;
  logic [31:0]      rword;
  logic [3:0]       rd_mask;
  int               rd_key;
  event             rd_ev;
  wire logic [14:0] key = {addr[19:16], addr_bit10, addr[14:5]};

  initial begin
    fb_clk = 1'b0;
    dq_in  = 32'h0000_0000;
  end

  always @(posedge clk_pin) begin
    if (cs_n !== 4'hF) begin
      if ({ras_n, cas_n, we_n} === 3'b100 && dq_oe_n === 1'b0) begin
        wword = mem.exists(key) ? mem[key] : 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
          if (!dqm[i]) wword[8*i +: 8] = dq_out[8*i +: 8];
        end
        mem[key] = wword;
      end
      if ({ras_n, cas_n, we_n} === 3'b101) begin
        rd_key  = key;
        rd_mask = dqm;
        -> rd_ev;
      end
    end
  end

  // ==========================================================================
  // Read frame
  // Masked lanes carry inverted data, because a lane with its drivers off shows no
  // stored value; the feedback clock stands low between frames.
  always begin
    @(rd_ev);
    if (slow) #(FB_HALF_NS * 6);
    rword = mem.exists(rd_key) ? mem[rd_key] : 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      dq_in[8*i +: 8] = rd_mask[i] ? ~rword[8*i +: 8] : rword[8*i +: 8];
    end
    // The frame ends on the last falling edge, so that a read issued straight
    // after the data came back still finds this process waiting for it.
    repeat (CAS_LATENCY + 1) begin
      #FB_HALF_NS fb_clk = 1'b1;
      #FB_HALF_NS fb_clk = 1'b0;
    end
    dq_in = ~dq_in;
  end
endmodule

/* File: tb/test_sdp_pin_interface.sv */
// Self-checking bench for the synchronous memory pin port with a behavioural memory.
// Assumes the package defaults: one CLK per half bus period and the default read latency.
`timescale 1ns/1ns
module test_sdp_pin_interface;
  import sdp_pkg::*;
  // ==========================================================================
  // Signals
  logic        clk          = 1'b0;
  logic        rstn         = 1'b0;
  logic [1:0]  clk_en       = 2'b11;
  logic        suspend      = 1'b0;
  logic        release_fl   = 1'b0;
  logic        req_valid    = 1'b0;
  sdp_cmd_t    req_cmd      = CMD_NOP;
  logic [1:0]  req_chip     = 2'h0;
  logic [14:0] req_addr     = 15'h0000;
  logic [3:0]  req_mask     = 4'h0;
  logic [31:0] wr_data      = 32'h0000_0000;
  logic        slow         = 1'b0;
  logic        req_ready;
  logic        rd_valid;
  logic [31:0] rd_data;
  logic [1:0]  mem_clk;
  logic        fb_clk;
  logic        cke;
  logic [3:0]  cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [3:0]  dqm;
  logic [19:0] maddr;
  logic        a10;
  logic [31:0] dq_in;
  logic [31:0] dq_out;
  logic        dq_oe_n;
  logic        flash_n;
  logic [1:0]  prev;
  int          errors       = 0;
  int          total_checks = 0;
  int          cycles       = 0;
  logic [31:0] ref_mem [int];
  logic [14:0] pool [4];
  logic [2:0]  strobe_tbl [8] = '{3'b111, 3'b011, 3'b101, 3'b100,
                                  3'b110, 3'b010, 3'b001, 3'b000};

  sdp_pin_interface i_sdp_pin_interface (
    .CLK(clk), .RSTN(rstn), .MEM_CLOCK_PIN_ENABLE(clk_en), .CLOCK_SUSPEND(suspend),
    .FLASH_RELEASE(release_fl), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_CMD(req_cmd), .REQ_CHIP(req_chip), .REQ_ADDR(req_addr), .REQ_BYTE_MASK(req_mask),
    .WR_DATA(wr_data), .RD_VALID(rd_valid), .RD_DATA(rd_data), .MEM_CLOCK_OUT(mem_clk),
    .MEM_FEEDBACK_CLOCK_IN(fb_clk), .MEM_CKE(cke), .MEM_CHIP_SELECT_N(cs_n),
    .MEM_ROW_STROBE_N(ras_n), .MEM_COL_STROBE_N(cas_n), .MEM_WRITE_STROBE_N(we_n),
    .MEM_DQM(dqm), .MEM_ADDR(maddr), .MEM_ADDR_BIT10(a10), .MEM_DQ_IN(dq_in),
    .MEM_DQ_OUT(dq_out), .MEM_DQ_OE_N(dq_oe_n), .FLASH_RESET_POWERDOWN_N(flash_n));

  sdp_mem_model i_sdp_mem_model (
    .clk_pin(mem_clk[0]), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .dqm(dqm), .addr(maddr), .addr_bit10(a10), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .slow(slow), .fb_clk(fb_clk), .dq_in(dq_in));

  // ==========================================================================
  // Helpers
  function automatic logic [19:0] pin_addr(input logic [14:0] a);
    pin_addr = {a[14:11], 1'b0, a[9:0], 5'h00};
  endfunction

  function automatic logic [31:0] lane_keep(input logic [3:0] m);
    for (int i = 0; i < 4; i++) lane_keep[8*i +: 8] = m[i] ? 8'h00 : 8'hFF;
  endfunction

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (!ok) begin
      errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Holds the request until the edge that takes it, then checks the pins just after that edge.
  task automatic issue(input sdp_cmd_t c, input logic [1:0] ch, input logic [14:0] a,
                       input logic [3:0] m, input logic [31:0] d);
    logic rdy;
    int   n;
    @(posedge clk);
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_chip  <= ch;
    req_addr  <= a;
    req_mask  <= m;
    wr_data   <= d;
    n = 0;
    do begin
      #1;
      rdy = req_ready;
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    req_valid <= 1'b0;
    #1;
    check(rdy === 1'b1, "request never taken");
    check({ras_n, cas_n, we_n} === strobe_tbl[c], "strobe levels");
    check(cs_n === ~(4'h1 << ch), "chip select");
    check(mem_clk[0] === 1'b0, "command not launched on falling clock");
    if (c == CMD_READ || c == CMD_WRITE) begin
      check(maddr === pin_addr(a) && a10 === a[10], "address pins");
      check(dqm === m, "byte mask pins");
    end
    if (c == CMD_WRITE) begin
      check(dq_out === d && dq_oe_n === 1'b0, "write data pins");
      ref_mem[a] = (ref_mem[a] & ~lane_keep(m)) | (d & lane_keep(m));
    end
    if (c == CMD_READ) begin
      n = 0;
      while (rd_valid !== 1'b1 && n < 300) begin
        @(posedge clk);
        #1;
        n++;
      end
      check((rd_data & lane_keep(m)) === (ref_mem[a] & lane_keep(m)), "read data");
      @(posedge clk);
      #1;
      check(rd_valid === 1'b0, "read valid longer than one cycle");
    end
  endtask

  // ==========================================================================
  // Clock, timeout and main sequence
  always #4 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    void'($urandom(32'h4683));
    repeat (5) @(posedge clk);
    #1;
    check(mem_clk === 2'b11 && cke === 1'b1 && cs_n === 4'hF, "reset clocks or selects");
    check({ras_n, cas_n, we_n} === 3'b111 && dqm === 4'hF, "reset strobes or masks");
    check(flash_n === 1'b0, "flash line not low in reset");
    @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check(flash_n === 1'b0, "flash line released early");
    for (int k = 0; k < 8; k++) begin
      prev = mem_clk;
      @(posedge clk);
      #1;
      check(mem_clk[0] === ~prev[0] && mem_clk[1] === mem_clk[0], "memory clock rate");
    end
    for (int e = 1; e < 3; e++) begin
      @(posedge clk);
      clk_en <= 2'(e);
      repeat (3) @(posedge clk);
      #1;
      for (int k = 0; k < 6; k++) begin
        prev = mem_clk;
        @(posedge clk);
        #1;
        check(mem_clk[e[0]] === 1'b0 && mem_clk[e[1]] === ~prev[e[1]], "clock pin enable");
      end
    end
    @(posedge clk);
    clk_en     <= 2'b11;
    release_fl <= 1'b1;
    suspend    <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(flash_n === 1'b1 && cke === 1'b0, "flash release or clock suspend");
    @(posedge clk);
    suspend <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(cke === 1'b1, "clock enable not restored");
    for (int i = 0; i < 4; i++) begin
      pool[i] = 15'($urandom);
      issue(CMD_WRITE, 2'(i), pool[i], 4'h0, $urandom);
    end
    issue(CMD_WRITE, 2'h3, pool[0], 4'hF, 32'hDEAD_BEEF);
    issue(CMD_READ, 2'h3, pool[0], 4'h0, 32'h0000_0000);
    for (int c = 1; c < 8; c++) issue(sdp_cmd_t'(c), 2'(c), pool[c % 4], 4'(c), $urandom);
    for (int i = 0; i < 40; i++) begin
      slow <= 1'($urandom);
      issue($urandom_range(1) ? CMD_WRITE : CMD_READ, 2'($urandom),
            pool[$urandom_range(3)], 4'($urandom), $urandom);
    end
    tally_and_finish();
  end
endmodule
